// >>> rtl/wdl_watchdog.v
`timescale 1ns/1ns
`default_nettype none
`include "wdl_regs.vh"
// Notes on behaviour
// - Reset timeout outside stop forces system reset
// - Normal timeout sets timeout flag when timeout_resets is set
// - Timeout in stop starts recovery when timeout_resets is set
// - Stop timeout sets timeout and stop flags when timeout_resets is set
// - Unlock is 55 then aa to control
// - Unlock writes leave control bits unchanged
// - Locked reload bytes ignore writes
// - Any other write resets lock sequence
// - Reload loads on enable and refresh
// - Control location is write only
module wdl_watchdog #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_b,
  // Host register writes
  input  wire             wr_en,
  input  wire [1:0]       wr_sel,
  input  wire [7:0]       wr_data,
  // Control inputs
  input  wire             wdt_enable,
  input  wire             timeout_resets,
  input  wire             refresh,
  input  wire             stop_mode,
  input  wire             flags_clear,
  // Status and actions
  output reg              watchdog_timeout_flag,
  output reg              stop_flag,
  output reg              system_reset_req,
  output reg              stop_recovery,
  output reg              timeout_event,
  output wire             reload_unlocked,
  output wire [WIDTH-1:0] reload_value,
  output reg  [WIDTH-1:0] count
);
  reg  [7:0] reload_upper_byte;  // Upper reload byte
  reg  [7:0] reload_high_byte;   // High reload byte
  reg  [7:0] reload_low_byte;    // Low reload byte
  reg        enable_seen;        // Last sampled enable, for the edge
  reg  [3:0] reset_cnt;          // Remaining forced reset cycles
  wire       upper_ok;           // Upper byte may be written now
  wire       high_ok;            // High byte may be written now
  wire       low_ok;             // Low byte may be written now
  wire       ctl_pattern;        // Control write is an unlock byte
  wire       expire;             // Counter at one and rearms this cycle
  wire       load;               // Copy reload into counter

  // Sequencer that grants reload writes one byte at a time
  wdl_lock u_lock (
    .clock       (clock),
    .rst_b       (rst_b),
    .wr_en       (wr_en),
    .wr_sel      (wr_sel),
    .wr_data     (wr_data),
    .upper_ok    (upper_ok),
    .high_ok     (high_ok),
    .low_ok      (low_ok),
    .ctl_pattern (ctl_pattern),
    .unlocked    (reload_unlocked)
  );

  assign reload_value = {reload_upper_byte, reload_high_byte,
                         reload_low_byte};

  // Reload bytes; default gives the longest period after reset
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reload_upper_byte <= 8'hff;
      reload_high_byte  <= 8'hff;
      reload_low_byte   <= 8'hff;
    end else if (wr_en) begin
      if (wr_sel == `WDL_SEL_UPPER && upper_ok) begin
        reload_upper_byte <= wr_data;
      end
      if (wr_sel == `WDL_SEL_HIGH && high_ok) begin
        reload_high_byte <= wr_data;
      end
      if (wr_sel == `WDL_SEL_LOW && low_ok) begin
        reload_low_byte <= wr_data;
      end
    end
  end

  // Expiry is a count of one while running with no load; it rearms instead of reaching zero
  assign expire = wdt_enable && !load && (count == {{(WIDTH-1){1'b0}}, 1'b1});
  // Load on enable edge or refresh
  assign load = wdt_enable && (!enable_seen || refresh);

  // Down counter; holds its value while disabled
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count       <= `WDL_RELOAD_RESET;
      enable_seen <= 1'b0;
    end else begin
      enable_seen <= wdt_enable;
      if (load) begin
        count <= reload_value;
      end else if (expire) begin
        // Rearm so a missed refresh keeps expiring each period
        count <= reload_value;
      end else if (wdt_enable && count != {WIDTH{1'b0}}) begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Time-out actions and sticky status; a new event beats a clear.
  // Control writes never touch these flags, the location is write only.
  // No control readback path
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_timeout_flag <= 1'b0;
      stop_flag             <= 1'b0;
      system_reset_req      <= 1'b0;
      stop_recovery         <= 1'b0;
      timeout_event         <= 1'b0;
      reset_cnt             <= 4'h0;
    end else begin
      timeout_event <= expire;
      stop_recovery <= 1'b0;
      if (flags_clear) begin
        watchdog_timeout_flag <= 1'b0;
        stop_flag             <= 1'b0;
      end
      if (reset_cnt != 4'h0) begin
        reset_cnt <= reset_cnt - 4'h1;
      end
      system_reset_req <= (reset_cnt > 4'h1);
      if (expire && timeout_resets) begin
        if (stop_mode) begin
          stop_recovery <= 1'b1;
          watchdog_timeout_flag <= 1'b1;
          stop_flag             <= 1'b1;
        end else begin
          reset_cnt        <= `WDL_RESET_CYCLES;
          system_reset_req <= 1'b1;
          watchdog_timeout_flag <= 1'b1;
          stop_flag             <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/wdl_regs.vh
`ifndef WDL_REGS_VH
`define WDL_REGS_VH
// Register write selects on the host write port
`define WDL_SEL_CONTROL     2'h0
`define WDL_SEL_UPPER       2'h1
`define WDL_SEL_HIGH        2'h2
`define WDL_SEL_LOW         2'h3
// Unlock pattern bytes
`define WDL_UNLOCK_FIRST    8'h55
`define WDL_UNLOCK_SECOND   8'haa
// Reload byte positions inside the 24-bit count
`define WDL_UPPER_MSB       23
`define WDL_UPPER_LSB       16
`define WDL_HIGH_MSB        15
`define WDL_HIGH_LSB        8
`define WDL_LOW_MSB         7
`define WDL_LOW_LSB         0
// Reset values
`define WDL_RELOAD_RESET    24'hffffff
`define WDL_STATE_RESET     3'h0
// Length of the forced reset pulse in cycles
`define WDL_RESET_CYCLES    4'h4
`endif

// >>> rtl/wdl_lock.v
`timescale 1ns/1ns
`default_nettype none
`include "wdl_regs.vh"
// Lock sequencer guarding the three reload byte registers
module wdl_lock (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // Register write strobe
  input  wire       wr_en,
  input  wire [1:0] wr_sel,
  input  wire [7:0] wr_data,
  // Write permissions
  output wire       upper_ok,
  output wire       high_ok,
  output wire       low_ok,
  output wire       ctl_pattern,
  output wire       unlocked
);
  // Sequence states
  localparam [2:0] S_LOCKED = 3'h0;
  localparam [2:0] S_GOT55  = 3'h1;
  localparam [2:0] S_UPPER  = 3'h2;
  localparam [2:0] S_HIGH   = 3'h3;
  localparam [2:0] S_LOW    = 3'h4;

  reg  [2:0] state;       // Current step of the sequence
  reg  [2:0] next_state;  // Step after this cycle

  // Permissions hold only while waiting for that exact byte
  assign upper_ok = (state == S_UPPER);
  assign high_ok  = (state == S_HIGH);
  assign low_ok   = (state == S_LOW);
  assign unlocked = upper_ok | high_ok | low_ok;
  assign ctl_pattern = wr_en && (wr_sel == `WDL_SEL_CONTROL) &&
    ((wr_data == `WDL_UNLOCK_FIRST && state == S_LOCKED) ||
     (wr_data == `WDL_UNLOCK_SECOND && state == S_GOT55));

  // Next step; any write out of order drops back to locked
  always @* begin
    next_state = state;
    if (wr_en) begin
      case (state)
        S_LOCKED: next_state = ctl_pattern ? S_GOT55 : S_LOCKED;
        S_GOT55:  next_state = ctl_pattern ? S_UPPER : S_LOCKED;
        S_UPPER:  next_state = (wr_sel == `WDL_SEL_UPPER) ? S_HIGH
                                                          : S_LOCKED;
        S_HIGH:   next_state = (wr_sel == `WDL_SEL_HIGH) ? S_LOW
                                                         : S_LOCKED;
        S_LOW:    next_state = S_LOCKED;
        default:  next_state = S_LOCKED;
      endcase
    end
  end

  // State register
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= `WDL_STATE_RESET;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// >>> bench/wdl_watchdog_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Watches time-out actions and the reload lock at the ports
module wdl_chk #(parameter WIDTH = 24) (
  // Clock, reset and host inputs
  input wire logic             clock, rst_b, wr_en, wdt_enable,
  input wire logic             timeout_resets, refresh, stop_mode,
  input wire logic [1:0]       wr_sel,
  input wire logic [7:0]       wr_data,
  // Design outputs
  input wire logic             watchdog_timeout_flag, stop_flag,
  input wire logic             system_reset_req, stop_recovery,
  input wire logic             reload_unlocked,
  input wire logic [WIDTH-1:0] reload_value, count
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic en_d;  // Enable a cycle ago; low marks the loading cycle
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) en_d <= 1'b0;
    else en_d <= wdt_enable;
  // Expiry due now; a load in the same cycle would rearm instead
  wire fire = wdt_enable && en_d && !refresh && count == 1 && timeout_resets;
  wire ctl = wr_en && wr_sel == 2'h0;
  property p_rst; fire && !stop_mode |=> system_reset_req[*4]; endproperty
  a_rst: assert property (p_rst) else $error("reset pulse wrong");
  property p_nfl; fire && !stop_mode |=> watchdog_timeout_flag && !stop_flag;
  endproperty
  a_nfl: assert property (p_nfl) else $error("normal flags wrong");
  property p_stp; fire && stop_mode |=> stop_recovery && !system_reset_req
    ##1 !stop_recovery; endproperty
  a_stp: assert property (p_stp) else $error("stop recovery wrong");
  property p_sfl; fire && stop_mode |=> watchdog_timeout_flag && stop_flag;
  endproperty
  a_sfl: assert property (p_sfl) else $error("stop flags wrong");
  property p_unl; ctl && wr_data == 8'h55 ##1 ctl && wr_data == 8'haa
    |=> reload_unlocked; endproperty
  a_unl: assert property (p_unl) else $error("unlock missed");
  property p_lck; wr_en && wr_sel != 2'h0 && !reload_unlocked
    |=> $stable(reload_value); endproperty
  a_lck: assert property (p_lck) else $error("locked write taken");
  property p_pair; (wr_en && wr_sel == 2'h1 && reload_unlocked)
    ##1 (wr_en && wr_sel == 2'h2 && reload_unlocked)
    ##1 (wr_en && wr_sel == 2'h3 && reload_unlocked) |=> !reload_unlocked
    && reload_value == {$past(wr_data, 3), $past(wr_data, 2), $past(wr_data)};
  endproperty
  a_pair: assert property (p_pair) else $error("reload bytes wrong");
  property p_load; wdt_enable && !en_d |=> count == $past(reload_value);
  endproperty
  a_load: assert property (p_load) else $error("enable load wrong");
  property p_rfl; wdt_enable && en_d && refresh
    |=> count == $past(reload_value); endproperty
  a_rfl: assert property (p_rfl) else $error("refresh load wrong");
endmodule
bind wdl_watchdog wdl_chk #(.WIDTH(WIDTH)) u_chk (.clock(clock),
  .rst_b(rst_b), .wr_en(wr_en), .wdt_enable(wdt_enable),
  .timeout_resets(timeout_resets), .refresh(refresh),
  .stop_mode(stop_mode), .wr_sel(wr_sel), .wr_data(wr_data),
  .watchdog_timeout_flag(watchdog_timeout_flag), .stop_flag(stop_flag),
  .system_reset_req(system_reset_req), .stop_recovery(stop_recovery),
  .reload_unlocked(reload_unlocked), .reload_value(reload_value),
  .count(count));
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Lock sequences, stray and locked writes, then a time-out each
module tb_top;
  logic clock, rst_b, wr_en, wdt_enable, timeout_resets, refresh;
  logic stop_mode, flags_clear;
  logic [1:0] wr_sel;
  logic [7:0] wr_data, lo;
  wire wtf, sf, srr, sr, ev, unl;
  wire [23:0] rv, cnt;
  logic [27:0] q[$];  // Expected flags and count, oldest first
  logic [23:0] rl;    // Reload the bench believes is in force
  int miscompares, check_count, cyc, k;
  wdl_watchdog #(.WIDTH(24)) uut (.clock(clock), .rst_b(rst_b),
    .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .wdt_enable(wdt_enable), .timeout_resets(timeout_resets),
    .refresh(refresh), .stop_mode(stop_mode), .flags_clear(flags_clear),
    .watchdog_timeout_flag(wtf), .stop_flag(sf), .system_reset_req(srr),
    .stop_recovery(sr), .timeout_event(ev), .reload_unlocked(unl),
    .reload_value(rv), .count(cnt));
  task chk(input logic [27:0] seen, input logic [27:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value status exp %h seen %h", exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One write per edge; the caller releases the strobe afterwards
  task wr(input logic [1:0] s, input logic [7:0] d);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Each expiry is matched against the oldest note; also the hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      miscompares++;
      results;
    end
    if (ev === 1'b1 && q.size() > 0)
      chk({wtf, sf, sr, srr, cnt}, q.pop_front());
    else if (ev === 1'b1)
      chk(28'h1, 28'h0);
  end
  initial begin
    {rst_b, wr_en, wdt_enable, refresh, stop_mode, flags_clear} = 6'h00;
    timeout_resets = 1'b1;
    wr_sel = 2'h0;
    wr_data = 8'h00;
    rl = 24'h000000;
    void'($urandom(32'h6614c24a));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // Kinds: 0 normal, 1 stop, 2 stray write, 3 locked
    for (k = 0; k < 8; k++) begin
      lo = 8'h04 + 8'($urandom % 8);
      if (k % 4 < 2) rl = {16'h0000, lo};
      if (k % 4 != 3) begin
        wr(2'h0, 8'h55);
        wr(2'h0, 8'haa);
      end
      // locked bytes ignored; upper, high, low in order
      wr(2'h1, (k % 4 == 3) ? 8'($urandom) : 8'h00);
      wr(2'h2, 8'h00);
      if (k % 4 == 2) wr(2'h0, 8'h12);
      wr(2'h3, lo);
      wr_en <= 1'b0;
      stop_mode <= (k % 4 == 1);
      wdt_enable <= 1'b1;
      q.push_back({1'b1, k % 4 == 1, k % 4 == 1, k % 4 != 1, rl});
      // refresh reload before the first expiry
      @(posedge clock);
      refresh <= 1'b1;
      @(posedge clock);
      refresh <= 1'b0;
      while (q.size() > 0) @(posedge clock);
      wdt_enable <= 1'b0;
      flags_clear <= 1'b1;
      @(posedge clock);
      flags_clear <= 1'b0;
      repeat (6) @(posedge clock);
      $display("test %0d kind %0d done", k, k % 4);
    end
    results;
  end
endmodule
`default_nettype wire
